// ---- console_pkg.sv ----
// Shared constants and types of the operator console controller.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package console_pkg;

	localparam logic [7:0] DEV_ADDR = 8'h01;
	localparam int BUS_AW = 10;
	localparam int IDX_W = 2;
	localparam logic [1:0] REG_SWLO = 2'h0;
	localparam logic [1:0] REG_SWHI = 2'h1;
	localparam logic [1:0] REG_STAT = 2'h2;
	localparam logic [1:0] REG_LAMP = 2'h3;
	localparam int CMD_ARM_BIT = 0;
	localparam int CMD_CLR_BIT = 7;
	localparam logic ARMED_RST = 1'b1;
	localparam logic [7:0] LAMP_RST = 8'h00;
	localparam logic [3:0] REGSEL_OFF = 4'h8;

	localparam int CLK_PERIOD_NS = 100;
	localparam int SECOND_NS = 1000000000;
	localparam int CYCLES_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
	localparam logic [6:0] SPEED_MAX = 7'h64;
	localparam logic [6:0] SPEED_SNGL = 7'h00;

	typedef enum logic [2:0] {
		MODE_RUN = 3'b000,
		MODE_HALT_FLT = 3'b001,
		MODE_HALT_FIX = 3'b010,
		MODE_VARI_FLT = 3'b011,
		MODE_VARI_FIX = 3'b100,
		MODE_ADRS = 3'b101,
		MODE_MEMR = 3'b110,
		MODE_MEMW = 3'b111
	} mode_type;

	typedef enum logic {
		SEQ_IDLE = 1'b0,
		SEQ_ACCESS = 1'b1
	} seq_type;

endpackage : console_pkg

// ---- panel_if.sv ----
// Carrier between the console controller and its button and rate helpers.
// Assumes all members are sampled on the one system clock.
interface panel_if;
	logic exec_btn;
	logic init_btn;
	logic exec_pulse;
	logic init_pulse;
	logic osc_en;
	logic [6:0] speed;
	logic osc_tick;

	modport ctrl (output exec_btn, init_btn, osc_en, speed,
		input exec_pulse, init_pulse, osc_tick);
	modport edges (input exec_btn, init_btn, output exec_pulse, init_pulse);
	modport osc (input osc_en, speed, output osc_tick);
endinterface : panel_if

// ---- press_edge.sv ----
// Turns the execute and initialize buttons into one-cycle press pulses.
// Assumes the buttons are already clean and synchronous to the clock.
module press_edge (
	input wire logic clk,
	input wire logic rst,
	panel_if.edges p
);
	logic exec_d_r;
	logic init_d_r;
	logic exec_p_r;
	logic init_p_r;

	assign p.exec_pulse = exec_p_r;
	assign p.init_pulse = init_p_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			exec_d_r <= 1'b0;
			init_d_r <= 1'b0;
			exec_p_r <= 1'b0;
			init_p_r <= 1'b0;
		end else begin
			exec_d_r <= p.exec_btn;
			init_d_r <= p.init_btn;
			exec_p_r <= p.exec_btn & ~exec_d_r;
			init_p_r <= p.init_btn & ~init_d_r;
		end
	end
endmodule : press_edge

// ---- rate_osc.sv ----
// Variable-rate oscillator: issues speed ticks per second, speed 1 to 100.
// Assumes speed is already clamped; a fractional accumulator keeps the rate.
module rate_osc #(
	parameter int CYCLES = console_pkg::CYCLES_PER_SEC
) (
	input wire logic clk,
	input wire logic rst,
	panel_if.osc p
);
	import console_pkg::*;
	localparam int ACC_W = $clog2(CYCLES + 128) + 1;
	localparam logic [ACC_W-1:0] LIMIT = ACC_W'(CYCLES);

	logic [ACC_W-1:0] acc_r;
	logic [ACC_W-1:0] acc_sum;
	logic wrap;
	logic tick_r;

	assign acc_sum = acc_r + ACC_W'(p.speed);
	assign wrap = acc_sum >= LIMIT;
	assign p.osc_tick = tick_r;

	always_ff @(posedge clk) begin
		if (rst || !p.osc_en) begin
			acc_r <= '0;
			tick_r <= 1'b0;
		end else begin
			acc_r <= wrap ? acc_sum - LIMIT : acc_sum;
			tick_r <= wrap;
		end
	end
endmodule : rate_osc

// ---- operator_console_controller.sv ----
// Operator console controller: panel switches, displays, console interrupt.
// Assumes processor-side strobes and panel inputs are synchronous to CLK.
//
// What this block does
// - Answers program I/O at device address 01
// - Every execute press raises a console interrupt
// - New mode applies only at execute press
// - Run mode: full speed, displays hold
// - Halt modes: stop, show selected register pair
// - Display format follows float or fixed variant
// - Variable speed: steps at rate, pair shown live
// - Address mode: switches load the location counter
// - Memory read: show data, address, then increment
// - Memory write: store switches, show, then increment
// - Single-step position: one instruction per press
// - Oscillator interrupts at one to hundred per second
// - Register selector applies only at execute press
// - Selector off position blanks both displays
// - Latched switch gives one, released gives zero
// - Initialize resets processor and all bus controllers
// - Wait lamp follows status word bit zero
// - Run plus execute while waiting resumes sequencing
// - Bus data moves as eight-bit bytes
// - Acknowledge stops here if pending and armed, returns address
//
// Design decisions made here: the register addresses and the plain strobed port.
module operator_console_controller #(
	parameter int OSC_CYCLES = console_pkg::CYCLES_PER_SEC
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [console_pkg::BUS_AW-1:0] BUS_ADDR,
	input wire logic [7:0] BUS_WDATA,
	input wire logic BUS_WR,
	input wire logic BUS_RD,
	output logic [7:0] BUS_RDATA,
	output logic ATTN,
	input wire logic ACK_IN,
	output logic ACK_OUT,
	output logic ACK_VALID,
	output logic [7:0] ACK_DEV,
	input wire logic EXEC_BTN,
	input wire logic INIT_BTN,
	input wire logic [2:0] MODE_SW,
	input wire logic [3:0] REGSEL_SW,
	input wire logic [6:0] SPEED_SW,
	input wire logic [15:0] DATA_SW,
	input wire logic PSW_WAIT,
	input wire logic [15:0] PSW_LC,
	input wire logic [15:0] GR_EVEN,
	input wire logic [15:0] GR_ODD,
	output logic [2:0] GR_PAIR,
	output logic [15:0] DISP1,
	output logic [15:0] DISP2,
	output logic DISP_BLANK,
	output logic FMT_FLOAT,
	output logic WAIT_LAMP,
	output logic RUN_EN,
	output logic STEP,
	output logic LC_LOAD,
	output logic LC_INC,
	output logic [15:0] LC_VALUE,
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [15:0] MEM_ADDR,
	output logic [15:0] MEM_WDATA,
	input wire logic [15:0] MEM_RDATA,
	input wire logic MEM_ACK,
	output logic SYS_INIT,
	output logic [7:0] PROG_LAMPS
);
	import console_pkg::*;

	////////////////////////////////////////////////////////////////////////
	panel_if pif ();

	logic rst_all;
	logic exec;
	mode_type mode_r;
	mode_type mode_new;
	logic [3:0] regsel_r;
	seq_type seq_r;
	logic run_r;
	logic attn_r;
	logic armed_r;
	logic vari_act;
	logic vari_new;
	logic halt_new;
	logic halted;
	logic single;
	logic osc_step;
	logic sel_off;
	logic sel_off_new;
	logic show_r;

	assign pif.exec_btn = EXEC_BTN;
	assign pif.init_btn = INIT_BTN;
	assign pif.speed = (SPEED_SW > SPEED_MAX) ? SPEED_MAX : SPEED_SW;
	assign single = SPEED_SW == SPEED_SNGL;
	assign pif.osc_en = vari_act & ~single;

	press_edge u_edge (
		.clk(CLK),
		.rst(RST),
		.p(pif.edges)
	);

	rate_osc #(
		.CYCLES(OSC_CYCLES)
	) u_osc (
		.clk(CLK),
		.rst(rst_all),
		.p(pif.osc)
	);

	// Initialize clears this controller and is sent on to the processor.
	assign rst_all = RST | pif.init_pulse;
	assign exec = pif.exec_pulse;
	assign mode_new = mode_type'(MODE_SW);
	assign vari_new = mode_new == MODE_VARI_FLT || mode_new == MODE_VARI_FIX;
	assign halt_new = mode_new == MODE_HALT_FLT || mode_new == MODE_HALT_FIX;
	assign vari_act = mode_r == MODE_VARI_FLT || mode_r == MODE_VARI_FIX;
	assign halted = ~run_r;
	assign sel_off = regsel_r >= REGSEL_OFF;
	assign sel_off_new = REGSEL_SW >= REGSEL_OFF;
	assign osc_step = vari_act & ~single & pif.osc_tick;

	always_ff @(posedge CLK) begin
		if (RST) begin
			SYS_INIT <= 1'b0;
		end else begin
			SYS_INIT <= pif.init_pulse;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode and selector are sampled only at an execute press.
	always_ff @(posedge CLK) begin
		if (rst_all) begin
			mode_r <= MODE_RUN;
			regsel_r <= REGSEL_OFF;
			show_r <= 1'b0;
		end else begin
			show_r <= exec && seq_r == SEQ_IDLE && halt_new;
			if (exec && seq_r == SEQ_IDLE) begin
				mode_r <= mode_new;
				regsel_r <= REGSEL_SW;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (rst_all) begin
			run_r <= 1'b1;
			STEP <= 1'b0;
		end else begin
			STEP <= 1'b0;
			if (exec && seq_r == SEQ_IDLE) begin
				run_r <= mode_new == MODE_RUN;
				STEP <= vari_new & single;
			end else if (osc_step) begin
				STEP <= 1'b1;
			end
		end
	end

	assign RUN_EN = run_r;
	assign GR_PAIR = regsel_r[2:0];

	////////////////////////////////////////////////////////////////////////
	// Displays: halt loads them once the new pair is selected; vari is live.
	logic disp_live;
	assign disp_live = vari_act & ~sel_off;

	always_ff @(posedge CLK) begin
		if (rst_all) begin
			DISP1 <= 16'h0000;
			DISP2 <= 16'h0000;
			DISP_BLANK <= 1'b1;
			FMT_FLOAT <= 1'b0;
		end else if (exec && seq_r == SEQ_IDLE && (halt_new || vari_new)) begin
			DISP_BLANK <= sel_off_new;
			FMT_FLOAT <= mode_new == MODE_HALT_FLT
				|| mode_new == MODE_VARI_FLT;
		end else if (show_r) begin
			DISP1 <= GR_EVEN;
			DISP2 <= GR_ODD;
		end else if (disp_live) begin
			DISP1 <= GR_EVEN;
			DISP2 <= GR_ODD;
		end else if (seq_r == SEQ_ACCESS && MEM_ACK) begin
			DISP1 <= MEM_ADDR;
			DISP2 <= MEM_WE ? MEM_WDATA : MEM_RDATA;
			DISP_BLANK <= 1'b0;
		end
	end

	chk_run_holds_disp: assert property (@(posedge CLK) disable iff (rst_all)
		mode_r == MODE_RUN && !exec && !$past(exec)
		&& seq_r == SEQ_IDLE |=> $stable(DISP1) && $stable(DISP2))
		else $error("display changed in run mode");

	chk_off_blanks: assert property (@(posedge CLK) disable iff (rst_all)
		exec && seq_r == SEQ_IDLE && (halt_new || vari_new) && sel_off_new
		|=> DISP_BLANK)
		else $error("off selector did not blank displays");

	chk_halt_shows_pair: assert property (@(posedge CLK) disable iff (rst_all)
		exec && seq_r == SEQ_IDLE && halt_new
		|=> GR_PAIR == $past(REGSEL_SW[2:0]) && !RUN_EN
		##1 DISP1 == $past(GR_EVEN) && DISP2 == $past(GR_ODD))
		else $error("halt did not show register pair");

	////////////////////////////////////////////////////////////////////////
	// Address load and memory access, both only while halted.
	seq_type seq_nxt;
	logic mem_go;
	assign mem_go = exec && halted && seq_r == SEQ_IDLE
		&& (mode_new == MODE_MEMR || mode_new == MODE_MEMW);
	assign seq_nxt = (seq_r == SEQ_IDLE) ? (mem_go ? SEQ_ACCESS : SEQ_IDLE)
		: (MEM_ACK ? SEQ_IDLE : SEQ_ACCESS);

	always_ff @(posedge CLK) begin
		if (rst_all) begin
			seq_r <= SEQ_IDLE;
			MEM_REQ <= 1'b0;
			MEM_WE <= 1'b0;
			MEM_ADDR <= 16'h0000;
			MEM_WDATA <= 16'h0000;
			LC_INC <= 1'b0;
			LC_LOAD <= 1'b0;
			LC_VALUE <= 16'h0000;
		end else begin
			seq_r <= seq_nxt;
			LC_INC <= 1'b0;
			LC_LOAD <= 1'b0;
			unique case (seq_r)
				SEQ_IDLE: begin
					if (mem_go) begin
						MEM_REQ <= 1'b1;
						MEM_WE <= mode_new == MODE_MEMW;
						MEM_ADDR <= PSW_LC;
						MEM_WDATA <= DATA_SW;
					end else if (exec && halted && mode_new == MODE_ADRS) begin
						LC_LOAD <= 1'b1;
						LC_VALUE <= DATA_SW;
					end
				end
				SEQ_ACCESS: begin
					if (MEM_ACK) begin
						MEM_REQ <= 1'b0;
						LC_INC <= 1'b1;
					end
				end
			endcase
		end
	end

	chk_adrs_load: assert property (@(posedge CLK) disable iff (rst_all)
		exec && halted && seq_r == SEQ_IDLE && mode_new == MODE_ADRS
		|=> LC_LOAD && LC_VALUE == $past(DATA_SW))
		else $error("address mode did not load counter");

	chk_mem_incr: assert property (@(posedge CLK) disable iff (rst_all)
		seq_r == SEQ_ACCESS && MEM_ACK
		|=> LC_INC && !MEM_REQ && DISP1 == $past(MEM_ADDR) ##1 !LC_INC)
		else $error("memory access did not show and increment");

	chk_memw_data: assert property (@(posedge CLK) disable iff (rst_all)
		mem_go && mode_new == MODE_MEMW
		|=> MEM_REQ && MEM_WE && MEM_WDATA == $past(DATA_SW)
		&& MEM_ADDR == $past(PSW_LC))
		else $error("memory write request wrong");

	////////////////////////////////////////////////////////////////////////
	// Console interrupt latch and daisy-chained acknowledge.
	logic attn_set;
	logic take_ack;
	assign attn_set = exec | osc_step;
	assign take_ack = ACK_IN & attn_r & armed_r;

	logic bus_hit;
	logic [1:0] bus_idx;
	logic cmd_wr;
	logic cmd_clr;
	assign bus_hit = BUS_ADDR[BUS_AW-1:IDX_W] == DEV_ADDR;
	assign bus_idx = BUS_ADDR[IDX_W-1:0];
	assign cmd_wr = BUS_WR & bus_hit & (bus_idx == REG_STAT);
	assign cmd_clr = cmd_wr & BUS_WDATA[CMD_CLR_BIT];

	// A new event in the clearing cycle is kept pending.
	always_ff @(posedge CLK) begin
		if (rst_all) begin
			attn_r <= 1'b0;
		end else begin
			attn_r <= attn_set | (attn_r & ~take_ack & ~cmd_clr);
		end
	end

	always_ff @(posedge CLK) begin
		if (rst_all) begin
			ACK_OUT <= 1'b0;
			ACK_VALID <= 1'b0;
			ACK_DEV <= 8'h00;
			ATTN <= 1'b0;
		end else begin
			ACK_OUT <= ACK_IN & ~take_ack;
			ACK_VALID <= take_ack;
			ACK_DEV <= take_ack ? DEV_ADDR : 8'h00;
			ATTN <= attn_r & armed_r & ~take_ack;
		end
	end

	chk_exec_raises: assert property (@(posedge CLK) disable iff (rst_all)
		exec |=> attn_r)
		else $error("execute press raised no interrupt");

	chk_ack_stops: assert property (@(posedge CLK) disable iff (rst_all)
		ACK_IN && attn_r && armed_r
		|=> ACK_VALID && !ACK_OUT && ACK_DEV == DEV_ADDR)
		else $error("pending acknowledge not taken");

	chk_ack_clears: assert property (@(posedge CLK) disable iff (rst_all)
		take_ack && !attn_set |=> !attn_r)
		else $error("acknowledged request still pending");

	chk_ack_passes: assert property (@(posedge CLK) disable iff (rst_all)
		ACK_IN && !(attn_r && armed_r) |=> ACK_OUT && !ACK_VALID)
		else $error("acknowledge not passed down");

	chk_single_step: assert property (@(posedge CLK) disable iff (rst_all)
		vari_act && single && !exec |=> !STEP)
		else $error("step without press at single position");

	////////////////////////////////////////////////////////////////////////
	// Program register access, one byte per strobe.
	logic [7:0] stat_byte;
	logic [7:0] rd_mux;
	assign stat_byte = {attn_r, armed_r, DISP_BLANK, FMT_FLOAT, run_r,
		mode_r};
	assign rd_mux = (bus_idx == REG_SWLO) ? DATA_SW[7:0]
		: (bus_idx == REG_SWHI) ? DATA_SW[15:8]
		: (bus_idx == REG_STAT) ? stat_byte : PROG_LAMPS;

	always_ff @(posedge CLK) begin
		if (rst_all) begin
			BUS_RDATA <= 8'h00;
			armed_r <= ARMED_RST;
			PROG_LAMPS <= LAMP_RST;
			WAIT_LAMP <= 1'b0;
		end else begin
			BUS_RDATA <= (BUS_RD && bus_hit) ? rd_mux : 8'h00;
			WAIT_LAMP <= PSW_WAIT;
			if (cmd_wr) begin
				armed_r <= BUS_WDATA[CMD_ARM_BIT];
			end
			if (BUS_WR && bus_hit && bus_idx == REG_LAMP) begin
				PROG_LAMPS <= BUS_WDATA;
			end
		end
	end

	chk_read_answer: assert property (@(posedge CLK) disable iff (rst_all)
		BUS_RD && bus_hit && bus_idx == REG_SWHI
		|=> BUS_RDATA == $past(DATA_SW[15:8]))
		else $error("switch byte read wrong");

	chk_wait_lamp: assert property (@(posedge CLK) disable iff (rst_all)
		PSW_WAIT ##1 PSW_WAIT |-> WAIT_LAMP)
		else $error("wait lamp not lit");

endmodule : operator_console_controller

// ---- cpu_side_model.sv ----
// Processor-side model: location counter, register pair and core memory.
// Assumes the console sends counter pulses and holds each memory request until acknowledged.
module cpu_side_model (
	input wire logic CLK,
	input wire logic RST,
	input wire logic SYS_INIT,
	input wire logic [2:0] MEM_DELAY,
	input wire logic MEM_REQ,
	input wire logic MEM_WE,
	input wire logic [15:0] MEM_ADDR,
	input wire logic [15:0] MEM_WDATA,
	output logic [15:0] MEM_RDATA,
	output logic MEM_ACK,
	input wire logic [2:0] GR_PAIR,
	output logic [15:0] GR_EVEN,
	output logic [15:0] GR_ODD,
	input wire logic LC_LOAD,
	input wire logic LC_INC,
	input wire logic [15:0] LC_VALUE,
	output logic [15:0] PSW_LC
);
	logic [15:0] mem [16];
	logic [2:0] wait_r;

	assign GR_EVEN = {8'he0, 5'h00, GR_PAIR};
	assign GR_ODD = {8'hd0, 5'h00, GR_PAIR};

	initial begin
		for (int i = 0; i < 16; i++) mem[i] = 16'hc000 | 16'(i);
	end

	// Read data outside the acknowledge cycle toggles, so stale use shows.
	always @(posedge CLK) begin
		if (RST || SYS_INIT) begin
			PSW_LC <= 16'h0000;
			MEM_ACK <= 1'b0;
			wait_r <= 3'h0;
			MEM_RDATA <= 16'hffff;
		end else begin
			if (LC_LOAD) PSW_LC <= LC_VALUE;
			else if (LC_INC) PSW_LC <= PSW_LC + 16'h0002;
			MEM_ACK <= 1'b0;
			MEM_RDATA <= ~MEM_RDATA;
			if (MEM_REQ && !MEM_ACK) begin
				wait_r <= wait_r + 3'h1;
				if (wait_r >= MEM_DELAY) begin
					MEM_ACK <= 1'b1;
					wait_r <= 3'h0;
					MEM_RDATA <= mem[MEM_ADDR[4:1]];
					if (MEM_WE) mem[MEM_ADDR[4:1]] <= MEM_WDATA;
				end
			end
		end
	end
endmodule : cpu_side_model

// ---- tb_top.sv ----
// Self-checking bench of the operator console controller.
// Assumes the processor-side model answers memory and counter traffic.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import console_pkg::*;
	logic CLK = 1'b0, RST = 1'b1, BUS_WR = 1'b0, BUS_RD = 1'b0, ACK_IN = 1'b0;
	logic EXEC_BTN = 1'b0, INIT_BTN = 1'b0, PSW_WAIT = 1'b0;
	logic [9:0] BUS_ADDR = 10'h000;
	logic [7:0] BUS_WDATA = 8'h00, BUS_RDATA, ACK_DEV, PROG_LAMPS;
	logic [2:0] MODE_SW = 3'h0, GR_PAIR, MEM_DELAY = 3'h0;
	logic [3:0] REGSEL_SW = 4'h8;
	logic [6:0] SPEED_SW = 7'h00;
	logic [15:0] DATA_SW = 16'h0000;
	logic ATTN, ACK_OUT, ACK_VALID, DISP_BLANK, FMT_FLOAT, WAIT_LAMP, RUN_EN;
	logic STEP, LC_LOAD, LC_INC, MEM_REQ, MEM_WE, MEM_ACK, SYS_INIT;
	logic [15:0] PSW_LC, GR_EVEN, GR_ODD, DISP1, DISP2, LC_VALUE;
	logic [15:0] MEM_ADDR, MEM_WDATA, MEM_RDATA;
	int errors = 0, n_checks = 0, n_step = 0, n_load = 0, n_inc = 0, n_init = 0;

	operator_console_controller #(.OSC_CYCLES(1000)) uut (.CLK, .RST,
		.BUS_ADDR, .BUS_WDATA, .BUS_WR, .BUS_RD, .BUS_RDATA, .ATTN, .ACK_IN,
		.ACK_OUT, .ACK_VALID, .ACK_DEV, .EXEC_BTN, .INIT_BTN, .MODE_SW,
		.REGSEL_SW, .SPEED_SW, .DATA_SW, .PSW_WAIT, .PSW_LC, .GR_EVEN, .GR_ODD,
		.GR_PAIR, .DISP1, .DISP2, .DISP_BLANK, .FMT_FLOAT, .WAIT_LAMP, .RUN_EN,
		.STEP, .LC_LOAD, .LC_INC, .LC_VALUE, .MEM_REQ, .MEM_WE, .MEM_ADDR,
		.MEM_WDATA, .MEM_RDATA, .MEM_ACK, .SYS_INIT, .PROG_LAMPS);
	cpu_side_model pm (.CLK, .RST, .SYS_INIT, .MEM_DELAY, .MEM_REQ, .MEM_WE,
		.MEM_ADDR, .MEM_WDATA, .MEM_RDATA, .MEM_ACK, .GR_PAIR, .GR_EVEN,
		.GR_ODD, .LC_LOAD, .LC_INC, .LC_VALUE, .PSW_LC);

	initial begin
		forever #50 CLK = ~CLK;
	end

	always @(posedge CLK) begin
		if (STEP === 1'b1) n_step++;
		if (LC_LOAD === 1'b1) n_load++;
		if (LC_INC === 1'b1) n_inc++;
		if (SYS_INIT === 1'b1) n_init++;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic count_in(string what, int lo, int hi, int got);
		n_checks++;
		if (got < lo || got > hi) begin
			errors++;
			$display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : count_in

	task automatic wr(logic [9:0] a, logic [7:0] d);
		@(posedge CLK);
		BUS_WR <= 1'b1;
		BUS_ADDR <= a;
		BUS_WDATA <= d;
		@(posedge CLK);
		BUS_WR <= 1'b0;
	endtask : wr

	task automatic rd(logic [9:0] a, output logic [7:0] d);
		@(posedge CLK);
		BUS_RD <= 1'b1;
		BUS_ADDR <= a;
		@(posedge CLK);
		BUS_RD <= 1'b0;
		#1;
		d = BUS_RDATA;
	endtask : rd

	task automatic ack(output logic [15:0] a);
		@(posedge CLK);
		ACK_IN <= 1'b1;
		@(posedge CLK);
		ACK_IN <= 1'b0;
		#1;
		a = {6'h00, ACK_OUT, ACK_VALID, ACK_DEV};
	endtask : ack

	task automatic step(int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : step

	task automatic press();
		n_step = 0;
		n_load = 0;
		n_inc = 0;
		@(posedge CLK);
		EXEC_BTN <= 1'b1;
		repeat (3) @(posedge CLK);
		EXEC_BTN <= 1'b0;
		step(10);
	endtask : press

	task automatic mem_op(logic [2:0] m, logic [15:0] sw);
		@(posedge CLK);
		MODE_SW <= m;
		DATA_SW <= sw;
		press();
	endtask : mem_op

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] d;
		rd(10'h006, d);
		check("status", 16'h0068, d);
		check("run", 16'h0001, RUN_EN);
		$display("reset test done");
	endtask : t_reset

	task automatic t_bus();
		logic [7:0] d;
		@(posedge CLK);
		DATA_SW <= 16'ha53c;
		rd(10'h004, d);
		check("switch low", 16'h003c, d);
		rd(10'h005, d);
		check("switch high", 16'h00a5, d);
		wr(10'h007, 8'h5a);
		wr(10'h00b, 8'hff);
		rd(10'h007, d);
		check("lamps", 16'h005a, d);
		check("lamp pins", 16'h005a, PROG_LAMPS);
		rd(10'h00b, d);
		check("foreign read", 16'h0000, d);
		$display("bus test done");
	endtask : t_bus

	task automatic t_panel();
		for (int m = 1; m < 5; m++) begin
			@(posedge CLK);
			MODE_SW <= 3'(m);
			REGSEL_SW <= 4'(m + 2);
			press();
			check("pair", 16'(m + 2), GR_PAIR);
			check("disp1", {8'he0, 8'(m + 2)}, DISP1);
			check("disp2", {8'hd0, 8'(m + 2)}, DISP2);
			check("float", 16'(m % 2), FMT_FLOAT);
			check("halted", 16'h0000, RUN_EN);
			count_in("steps", m / 3, m / 3, n_step);
		end
		@(posedge CLK);
		MODE_SW <= MODE_RUN;
		REGSEL_SW <= 4'h1;
		step(6);
		check("mode held", 16'h0000, RUN_EN);
		check("pair held", 16'h00d0 << 8 | 16'h0006, DISP2);
		$display("panel test done");
	endtask : t_panel

	task automatic t_irq();
		logic [15:0] a;
		mem_op(MODE_HALT_FLT, 16'h0000);
		check("attn set", 16'h0001, ATTN);
		ack(a);
		check("ack stop", 16'h0101, a);
		step(2);
		check("attn clear", 16'h0000, ATTN);
		ack(a);
		check("ack pass", 16'h0200, a);
		wr(10'h006, 8'h00);
		press();
		check("disarmed", 16'h0000, ATTN);
		wr(10'h006, 8'h01);
		step(2);
		check("rearmed", 16'h0001, ATTN);
		wr(10'h006, 8'h81);
		step(2);
		check("cleared", 16'h0000, ATTN);
		$display("interrupt test done");
	endtask : t_irq

	task automatic t_off();
		@(posedge CLK);
		REGSEL_SW <= REGSEL_OFF;
		press();
		check("blank", 16'h0001, DISP_BLANK);
		@(posedge CLK);
		REGSEL_SW <= 4'h2;
		press();
		check("lit", 16'h0000, DISP_BLANK);
		$display("selector off test done");
	endtask : t_off

	task automatic t_mem();
		mem_op(MODE_ADRS, 16'h0010);
		count_in("loads", 1, 1, n_load);
		check("counter", 16'h0010, PSW_LC);
		mem_op(MODE_MEMR, 16'h0010);
		check("read addr", 16'h0010, DISP1);
		check("read data", 16'hc008, DISP2);
		count_in("read incs", 1, 1, n_inc);
		@(posedge CLK);
		MEM_DELAY <= 3'h3;
		mem_op(MODE_MEMW, 16'h7e81);
		check("write addr", 16'h0012, DISP1);
		check("write data", 16'h7e81, DISP2);
		count_in("write incs", 1, 1, n_inc);
		mem_op(MODE_ADRS, 16'h0012);
		mem_op(MODE_MEMR, 16'h0012);
		check("stored", 16'h7e81, DISP2);
		$display("memory test done");
	endtask : t_mem

	task automatic t_run();
		@(posedge CLK);
		PSW_WAIT <= 1'b1;
		MODE_SW <= MODE_RUN;
		step(3);
		check("wait lamp", 16'h0001, WAIT_LAMP);
		check("not yet", 16'h0000, RUN_EN);
		press();
		check("resumed", 16'h0001, RUN_EN);
		check("display hold", 16'h7e81, DISP2);
		@(posedge CLK);
		PSW_WAIT <= 1'b0;
		step(2);
		check("lamp off", 16'h0000, WAIT_LAMP);
		mem_op(MODE_ADRS, 16'h0040);
		count_in("running adrs", 0, 0, n_load);
		check("counter kept", 16'h0014, PSW_LC);
		$display("run test done");
	endtask : t_run

	task automatic t_vari();
		@(posedge CLK);
		MODE_SW <= MODE_VARI_FIX;
		SPEED_SW <= SPEED_MAX;
		press();
		n_step = 0;
		step(1000);
		count_in("fast steps", 99, 101, n_step);
		@(posedge CLK);
		SPEED_SW <= 7'h01;
		step(5);
		n_step = 0;
		step(3000);
		count_in("slow steps", 2, 4, n_step);
		$display("variable speed test done");
	endtask : t_vari

	task automatic t_init();
		logic [7:0] d;
		n_init = 0;
		@(posedge CLK);
		INIT_BTN <= 1'b1;
		repeat (3) @(posedge CLK);
		INIT_BTN <= 1'b0;
		step(6);
		count_in("init pulses", 1, 1, n_init);
		check("init lamps", 16'h0000, PROG_LAMPS);
		rd(10'h006, d);
		check("init status", 16'h0068, d);
		$display("initialize test done");
	endtask : t_init

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report

	initial begin
		repeat (4) @(posedge CLK);
		RST <= 1'b0;
		t_reset();
		t_bus();
		t_panel();
		t_irq();
		t_off();
		t_mem();
		t_run();
		t_vari();
		t_init();
		final_report();
	end

	initial begin
		#2000000;
		errors++;
		final_report();
	end
endmodule : tb_top
